/* tb/rsct_far_model.sv */
// Far side model: power monitors, reset pin with pull-up, core
`timescale 1ns/1ps
module rsct_far_model (
  input wire logic i_clk,
  output rsct_pkg::rsct_events_t o_evt,
  output logic o_pin_n,
  output logic o_sleeping,
  output logic o_gie
);
  import rsct_pkg::*;
  logic pin_hold = 1'b0;
  initial begin
    o_evt = '0;
    o_sleeping = 1'b0;
    o_gie = 1'b0;
  end
  // Weak pull-up: a released pin reads high, never the last value
  assign o_pin_n = pin_hold ? 1'b0 : 1'b1;
  // One-cycle event; any event, reset or wake, also ends the sleep request
  task automatic pulse(input logic [7:0] e);
    @(posedge i_clk);
    o_evt <= e;
    o_sleeping <= 1'b0;
    @(posedge i_clk);
    o_evt <= '0;
  endtask
  task automatic set_pin(input logic hold);
    @(posedge i_clk);
    pin_hold <= hold;
  endtask
  task automatic set_core(input logic s, input logic g);
    @(posedge i_clk);
    o_sleeping <= s;
    o_gie <= g;
  endtask
endmodule

/* tb/rsct_top_bench.sv */
// Self-checking testbench for the reset start and cause tracker
`timescale 1ns/1ps
module rsct_top_bench;
  import rsct_pkg::*;
  localparam int PWRT = 8;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [1:0] i_addr;
  logic [7:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic i_bor_ready;
  rsct_events_t evt;
  logic pin_n, slp, global_interrupt_enable, o_run, o_pc_load, o_pc_next, o_int_vector;
  logic [7:0] o_rdata, v, c0, s0, d;
  logic [15:0] o_pc_value;
  logic [31:0] lfsr = 32'h4345BF1A;
  int fail_count = 0;
  int tests_run = 0;
  int n;
  logic [7:0] evts [6] = '{8'h20, 8'h40, 8'h10, 8'h08, 8'h04, 8'h80};
  rsct_top #(.PWRT_CYCLES(PWRT)) i_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_evt(evt), .i_sleeping(slp),
    .i_gie(global_interrupt_enable), .i_bor_ready(i_bor_ready), .i_ext_reset_pin_n(pin_n), .o_rdata(o_rdata),
    .o_run(o_run), .o_pc_load(o_pc_load), .o_pc_value(o_pc_value),
    .o_pc_next(o_pc_next), .o_int_vector(o_int_vector));
  rsct_far_model i_far (.i_clk(i_clk), .o_evt(evt), .o_pin_n(pin_n), .o_sleeping(slp),
    .o_gie(global_interrupt_enable));
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  // Next state of the stimulus shift register
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected cause flags after a reset event, from the flags before it
  function automatic logic [7:0] exp_cause(input logic [7:0] e, input logic [7:0] c);
    case (e)
      8'h80: return 8'h1C;
      8'h40: return {3'b000, c[4], 2'b11, c[1], 1'b0};
      8'h20: return c & 8'hEF;
      8'h10: return c & 8'hFB;
      8'h08: return c | 8'h80;
      8'h04: return c | 8'h40;
      default: return c;
    endcase
  endfunction
  task automatic check(input string nm, input logic [17:0] seen, input logic [17:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] dat);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= dat;
    @(posedge i_clk);
    i_wr <= 1'b0;
    // Junk on address and data between strobes must be ignored
    i_addr <= lfsr[10:9];
    i_wdata <= lfsr[23:16];
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, output logic [7:0] dat);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    i_addr <= lfsr[12:11];
    #1;
    dat = o_rdata;
  endtask
  // Bounded wait for a start or wake pulse, counting cycles
  task automatic wait_pc(output int cnt);
    cnt = 0;
    #1;
    while (o_pc_load !== 1'b1 && o_pc_next !== 1'b1 && cnt < 300) begin
      @(posedge i_clk);
      #1;
      cnt++;
    end
    if (cnt >= 300) check("start pulse", 18'h0, 18'h1);
  endtask
  task automatic wake(input logic [7:0] e, input logic g, input logic [7:0] st);
    rd(ADDR_CAUSE, c0);
    i_far.set_core(1'b1, g);
    repeat (3) @(posedge i_clk);
    i_far.pulse(e);
    wait_pc(n);
    check("pc next", o_pc_next, 1);
    @(posedge i_clk);
    #1;
    check("vector", {o_int_vector, o_pc_load, o_pc_value}, g ? {2'b11, INT_VECTOR} : 0);
    rd(ADDR_CORE_STAT, d);
    check("wake status", d, st);
    rd(ADDR_CAUSE, d);
    check("wake cause", d, c0);
  endtask
  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Watchdog: the whole sequence needs a few hundred cycles
  initial begin
    #300000;
    fail_count++;
    complete_run();
  end
  initial begin
    i_addr <= 2'h0;
    i_wdata <= 8'h00;
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    i_bor_ready <= 1'b0;
    repeat (16) @(posedge i_clk);
    i_rstn <= 1'b1;
    wait_pc(n);
    check("first start", {o_run, o_pc_load, o_pc_value}, {2'b11, RESET_VECTOR});
    rd(ADDR_CAUSE, d);
    check("cause reset", d, 8'h1C);
    rd(ADDR_CORE_STAT, d);
    check("status reset", d, 8'h18);
    rd(ADDR_CONFIG, d);
    check("config reset", d, CFG_RESET);
    // Random firmware writes: flags set back, bit 5 and status ignored
    for (int i = 0; i < 8; i++) begin
      lfsr = lfsr_next(lfsr);
      v = lfsr[7:0];
      @(posedge i_clk);
      i_bor_ready <= lfsr[8];
      wr(ADDR_CAUSE, v & 8'h3F);
      rd(ADDR_CAUSE, d);
      check("cause write", d, v & 8'h1F);
      wr(ADDR_BOR_CTRL, v);
      rd(ADDR_BOR_CTRL, d);
      check("bor ctrl", d, {v[7:6], 5'h00, lfsr[8]});
      wr(ADDR_CORE_STAT, v);
      rd(ADDR_CORE_STAT, d);
      check("status write", d, 8'h18);
    end
    $display("Done: register writes");
    wr(ADDR_CAUSE, 8'h1F);
    foreach (evts[i]) begin
      rd(ADDR_CAUSE, c0);
      i_far.pulse(evts[i]);
      wait_pc(n);
      check("restart", {o_pc_load, o_pc_value}, {1'b1, RESET_VECTOR});
      rd(ADDR_CAUSE, d);
      v = (evts[i] == 8'h80) ? 8'hFE : 8'hFF;
      check("cause", d & v, exp_cause(evts[i], c0) & v);
      rd(ADDR_CORE_STAT, d);
      check("status", d[4], evts[i] != 8'h20);
    end
    $display("Done: reset causes");
    wr(ADDR_CAUSE, 8'h1F);
    wr(ADDR_CONFIG, 8'h0B);
    i_far.pulse(8'h08);
    repeat (20) @(posedge i_clk);
    rd(ADDR_CAUSE, d);
    check("stack off", {o_run, d}, {1'b1, 8'h1F});
    wr(ADDR_CONFIG, 8'h0C);
    i_far.set_pin(1'b1);
    repeat (6) @(posedge i_clk);
    #1;
    check("pin off", o_run, 1);
    i_far.set_pin(1'b0);
    wr(ADDR_CONFIG, 8'h0E);
    i_far.set_pin(1'b1);
    repeat (6) @(posedge i_clk);
    #1;
    check("pin held", o_run, 0);
    i_far.set_pin(1'b0);
    wait_pc(n);
    check("pin start delay", n >= 10 && n <= 14, 1);
    rd(ADDR_CAUSE, d);
    check("pin cause", d, 8'h17);
    $display("Done: pin reset");
    wr(ADDR_CONFIG, 8'h07);
    i_far.set_pin(1'b1);
    i_far.pulse(8'h80);
    repeat (3 * PWRT) @(posedge i_clk);
    i_far.set_pin(1'b0);
    wait_pc(n);
    check("timer then pin", n >= 10 && n <= 14, 1);
    wake(8'h02, 1'b0, 8'h00);
    wake(8'h01, 1'b0, 8'h10);
    wake(8'h01, 1'b1, 8'h10);
    wr(ADDR_CAUSE, 8'h1F);
    i_far.set_core(1'b1, 1'b0);
    repeat (3) @(posedge i_clk);
    i_far.set_pin(1'b1);
    i_far.set_core(1'b0, 1'b0);
    repeat (4) @(posedge i_clk);
    i_far.set_pin(1'b0);
    wait_pc(n);
    rd(ADDR_CORE_STAT, d);
    rd(ADDR_CAUSE, v);
    check("sleep pin", {d, v}, {8'h10, 8'h17});
    $display("Done: sleep and wake");
    // Mid-run reset acts like a power-on and shows no false pin edge
    @(posedge i_clk);
    i_rstn <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_rstn <= 1'b1;
    wait_pc(n);
    check("mid start", {o_run, o_pc_load, o_pc_value}, {2'b11, RESET_VECTOR});
    rd(ADDR_CAUSE, d);
    check("mid reset cause", d, 8'h1C);
    rd(ADDR_CONFIG, d);
    check("mid reset config", d, CFG_RESET);
    $display("Done: mid-run reset");
    complete_run();
  end
endmodule

/* verilog/rsct_pkg.sv */
// Package for the reset start and cause tracker: offsets, fields, states
package rsct_pkg;
  // Register indices on the plain register port
  localparam logic [1:0] ADDR_CAUSE = 2'h0;
  localparam logic [1:0] ADDR_BOR_CTRL = 2'h1;
  localparam logic [1:0] ADDR_CORE_STAT = 2'h2;
  localparam logic [1:0] ADDR_CONFIG = 2'h3;
  // Cause flag register fields
  localparam int CF_STK_OVF = 7;
  localparam int CF_STK_UNF = 6;
  localparam int CF_WDT_N = 4;
  localparam int CF_PIN_N = 3;
  localparam int CF_INSTR_N = 2;
  localparam int CF_POR_N = 1;
  localparam int CF_BOR_N = 0;
  localparam logic [7:0] CF_IMPL_MASK = 8'hDF;
  // Core status fields
  localparam int ST_TO_N = 4;
  localparam int ST_PD_N = 3;
  // Brownout control fields
  localparam int BC_SW_EN = 7;
  localparam int BC_FAST = 6;
  localparam int BC_READY = 0;
  localparam logic [7:0] BC_RESET = 8'h80;
  // Configuration register fields (own register)
  localparam int CFG_PIN_EN = 0;
  localparam int CFG_LVP = 1;
  localparam int CFG_STK_EN = 2;
  localparam int CFG_PWRT_N = 3;
  localparam logic [7:0] CFG_RESET = 8'h0F;
  // Vectors
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] INT_VECTOR = 16'h0004;
  // Delay from pin release to start, in oscillator cycles
  localparam int PIN_START_CYC = 10;
  // Sequencer states, Gray coded along the start path
  typedef enum logic [1:0] {
    RSCT_HOLD = 2'b00,
    RSCT_WAIT = 2'b01,
    RSCT_RUN = 2'b11,
    RSCT_SLEEP = 2'b10
  } rsct_state_t;
  // Reset and wake event group from the monitors and core
  typedef struct packed {
    logic por;
    logic bor;
    logic wdt;
    logic instr;
    logic stk_ovf;
    logic stk_unf;
    logic wake_wdt;
    logic wake_int;
  } rsct_events_t;
endpackage

/* verilog/rsct_top.sv */
// Reset start sequencer and reset cause register block
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module rsct_top #(
  parameter int PWRT_CYCLES = 6400
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire rsct_pkg::rsct_events_t i_evt,
  input wire logic i_sleeping,
  input wire logic i_gie,
  input wire logic i_bor_ready,
  input wire logic i_ext_reset_pin_n,
  output logic [7:0] o_rdata,
  output logic o_run,
  output logic o_pc_load,
  output logic [15:0] o_pc_value,
  output logic o_pc_next,
  output logic o_int_vector
);
  import rsct_pkg::*;

  localparam int PWRT_W = $clog2(PWRT_CYCLES + 1);
  localparam int PIN_W = $clog2(PIN_START_CYC + 1);

  initial begin
    if (PWRT_CYCLES < 1) begin
      $error("PWRT_CYCLES must be at least one");
    end
  end

  // Pin synchroniser, first stage read only by the second
  logic pin_s1_reg;
  logic pin_s2_reg;
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      // Idle level of the pulled-up pin, so no false falling edge after reset
      pin_s1_reg <= 1'b1;
      pin_s2_reg <= 1'b1;
    end else begin
      pin_s1_reg <= i_ext_reset_pin_n;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  logic [7:0] cause_reg, cause_next;
  logic [7:0] bctl_reg, bctl_next;
  logic [1:0] stat_reg, stat_next;
  logic [7:0] cfg_reg, cfg_next;
  rsct_state_t state_reg, state_next;
  logic [PWRT_W-1:0] pwrt_reg, pwrt_next;
  logic [PIN_W-1:0] pin_cnt_reg, pin_cnt_next;
  logic pin_prev_reg, pin_prev_next;
  logic wake_vec_reg, wake_vec_next;
  logic [7:0] rdata_next;
  logic run_next, pc_load_next, pc_next_next, int_vec_next;
  logic [15:0] pc_value_next;
  logic pin_en, pin_low, pin_rst_evt, stk_ovf_rst, stk_unf_rst, pwrt_done;

  // Pin function gate and reset qualifiers
  always_comb begin
    pin_en = cfg_reg[CFG_PIN_EN] | cfg_reg[CFG_LVP];
    pin_low = pin_en & ~pin_s2_reg;
    pin_rst_evt = pin_low & pin_prev_reg; // Falling edge of an enabled pin
    stk_ovf_rst = i_evt.stk_ovf & cfg_reg[CFG_STK_EN];
    stk_unf_rst = i_evt.stk_unf & cfg_reg[CFG_STK_EN];
    pwrt_done = cfg_reg[CFG_PWRT_N] | (pwrt_reg == PWRT_W'(PWRT_CYCLES));
  end

  // Cause flags, status bits and start sequencer
  always_comb begin
    cause_next = cause_reg;
    bctl_next = bctl_reg;
    stat_next = stat_reg;
    cfg_next = cfg_reg;
    state_next = state_reg;
    pwrt_next = pwrt_reg;
    pin_cnt_next = pin_cnt_reg;
    pin_prev_next = ~pin_low;
    wake_vec_next = 1'b0;
    pc_load_next = 1'b0;
    pc_next_next = 1'b0;
    int_vec_next = 1'b0;
    pc_value_next = o_pc_value;
    // Firmware writes come first so hardware events below win
    if (i_wr) begin
      unique case (i_addr)
        ADDR_CAUSE: cause_next = i_wdata & CF_IMPL_MASK;
        ADDR_BOR_CTRL: begin
          bctl_next[BC_SW_EN] = i_wdata[BC_SW_EN];
          bctl_next[BC_FAST] = i_wdata[BC_FAST];
        end
        ADDR_CORE_STAT: ; // Status bits are read only here
        ADDR_CONFIG: cfg_next = {4'h0, i_wdata[3:0]};
      endcase
    end
    bctl_next[BC_READY] = i_bor_ready;
    // Pin release counter outside the event chain: a power-on leaves its count running
    if (pin_low) begin
      pin_cnt_next = '0;
    end else if (pin_cnt_reg != PIN_W'(PIN_START_CYC)) begin
      pin_cnt_next = pin_cnt_reg + PIN_W'(1);
    end
    // Event priority: power-on, brownout, then the rest
    if (i_evt.por) begin
      cause_next = 8'h1C;
      stat_next = 2'b11;
      state_next = RSCT_WAIT;
      pwrt_next = '0;
      bctl_next[BC_SW_EN] = BC_RESET[BC_SW_EN];
      bctl_next[BC_FAST] = BC_RESET[BC_FAST];
    end else if (i_evt.bor) begin
      cause_next = {2'b00, 1'b0, cause_reg[CF_WDT_N], 2'b11, cause_reg[CF_POR_N], 1'b0};
      stat_next = 2'b11;
      state_next = RSCT_WAIT;
      pwrt_next = '0;
    end else begin
      if (i_evt.wdt && state_reg != RSCT_SLEEP) begin
        cause_next[CF_WDT_N] = 1'b0;
        stat_next[1] = 1'b0;
        state_next = RSCT_WAIT;
      end
      if (pin_rst_evt) begin
        cause_next[CF_PIN_N] = 1'b0;
        if (state_reg == RSCT_SLEEP) begin
          stat_next = 2'b10;
        end
        state_next = RSCT_WAIT;
      end
      if (i_evt.instr) begin
        cause_next[CF_INSTR_N] = 1'b0;
        state_next = RSCT_WAIT;
      end
      if (stk_ovf_rst) begin
        cause_next[CF_STK_OVF] = 1'b1;
        state_next = RSCT_WAIT;
      end
      if (stk_unf_rst) begin
        cause_next[CF_STK_UNF] = 1'b1;
        state_next = RSCT_WAIT;
      end
      // Sleep tracking and wake-ups
      if (state_reg == RSCT_RUN && i_sleeping) begin
        state_next = RSCT_SLEEP;
        stat_next[0] = 1'b0;
      end
      if (state_reg == RSCT_SLEEP && !pin_rst_evt) begin
        if (i_evt.wake_wdt) begin
          stat_next = 2'b00;
          state_next = RSCT_RUN;
          pc_next_next = 1'b1;
        end else if (i_evt.wake_int) begin
          stat_next = 2'b10;
          state_next = RSCT_RUN;
          pc_next_next = 1'b1;
          wake_vec_next = i_gie;
        end
      end
      // Power timer counts up to PWRT_CYCLES and stops there, whatever the pin does
      if (!pwrt_done) begin
        pwrt_next = pwrt_reg + PWRT_W'(1);
      end
      if (state_reg == RSCT_WAIT && state_next == RSCT_WAIT && pwrt_done && !pin_low &&
          pin_cnt_reg == PIN_W'(PIN_START_CYC)) begin
        state_next = RSCT_RUN;
        pc_load_next = 1'b1;
        pc_value_next = RESET_VECTOR;
      end
    end
    // Hold in reset while enabled pin is low
    if (pin_low && state_next != RSCT_HOLD) begin
      state_next = RSCT_WAIT;
    end
    if (state_next == RSCT_WAIT) begin
      pc_load_next = 1'b0;
    end
    // Vector jump one cycle after the next instruction
    if (wake_vec_reg) begin
      int_vec_next = 1'b1;
      pc_load_next = 1'b1;
      pc_value_next = INT_VECTOR;
    end
    run_next = (state_next == RSCT_RUN) || (state_next == RSCT_SLEEP);
  end

  // Read mux, data stands the cycle after the strobe
  always_comb begin
    rdata_next = 8'h00;
    if (i_rd) begin
      unique case (i_addr)
        ADDR_CAUSE: rdata_next = cause_reg & CF_IMPL_MASK;
        ADDR_BOR_CTRL: rdata_next = bctl_reg;
        ADDR_CORE_STAT: rdata_next = {3'b000, stat_reg, 3'b000};
        ADDR_CONFIG: rdata_next = cfg_reg;
      endcase
    end
  end

  // State registers; synchronous reset acts like a power-on
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      cause_reg <= 8'h1C;
      bctl_reg <= BC_RESET;
      stat_reg <= 2'b11;
      cfg_reg <= CFG_RESET;
      state_reg <= RSCT_HOLD;
      pwrt_reg <= '0;
      pin_cnt_reg <= '0;
      pin_prev_reg <= 1'b1;
      wake_vec_reg <= 1'b0;
      o_rdata <= 8'h00;
      o_run <= 1'b0;
      o_pc_load <= 1'b0;
      o_pc_value <= RESET_VECTOR;
      o_pc_next <= 1'b0;
      o_int_vector <= 1'b0;
    end else begin
      cause_reg <= cause_next;
      bctl_reg <= bctl_next;
      stat_reg <= stat_next;
      cfg_reg <= cfg_next;
      state_reg <= (state_reg == RSCT_HOLD && state_next == RSCT_HOLD) ? RSCT_WAIT : state_next;
      pwrt_reg <= pwrt_next;
      pin_cnt_reg <= pin_cnt_next;
      pin_prev_reg <= pin_prev_next;
      wake_vec_reg <= wake_vec_next;
      o_rdata <= rdata_next;
      o_run <= run_next;
      o_pc_load <= pc_load_next;
      o_pc_value <= pc_value_next;
      o_pc_next <= pc_next_next;
      o_int_vector <= int_vec_next;
    end
  end

  // Check helper: cycles the enabled pin has stood high, saturating
  logic [3:0] chk_high_reg, chk_high_next;
  always_comb begin
    chk_high_next = chk_high_reg;
    if (pin_low) begin
      chk_high_next = 4'h0;
    end else if (chk_high_reg != 4'hF) begin
      chk_high_next = chk_high_reg + 4'h1;
    end
  end

  // Helper register, kept apart from the counter that drives the start
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      chk_high_reg <= 4'h0;
    end else begin
      chk_high_reg <= chk_high_next;
    end
  end

  // Checks on the visible behaviour
  sequence s_int_wake;
    (state_reg == RSCT_SLEEP) && i_evt.wake_int && !i_evt.wake_wdt && i_gie &&
      !i_evt.por && !i_evt.bor && !pin_rst_evt;
  endsequence

  a_por_flags: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_evt.por |=> (cause_reg == 8'h1C) && (stat_reg == 2'b11))
    else $error("power-on flags wrong");
  a_bor_keeps: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_evt.bor && !i_evt.por) |=> !cause_reg[CF_BOR_N] &&
      cause_reg[CF_POR_N] == $past(cause_reg[CF_POR_N]))
    else $error("brownout flags wrong");
  a_bit5_zero: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_rd && i_addr == ADDR_CAUSE) |=> !o_rdata[5])
    else $error("bit 5 not zero");
  a_stk_gate: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (!cfg_reg[CFG_STK_EN] && !i_evt.por && !i_evt.bor && !(i_wr && i_addr == ADDR_CAUSE) &&
      !cause_reg[CF_STK_OVF]) |=> !cause_reg[CF_STK_OVF])
    else $error("stack flag without enable");
  a_wake_vector: assert property (@(posedge i_clk) disable iff (!i_rstn)
    s_int_wake |=> o_pc_next ##1 (o_int_vector && o_pc_value == INT_VECTOR))
    else $error("interrupt vector not taken");
  a_pin_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
    pin_low |=> !o_run)
    else $error("running while pin held");
  a_wdt_wake: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (state_reg == RSCT_SLEEP && i_evt.wake_wdt && !i_evt.por && !i_evt.bor && !pin_rst_evt)
      |=> stat_reg == 2'b00 && o_pc_next)
    else $error("watchdog wake bits wrong");
  a_pin_start: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (state_reg == RSCT_WAIT && chk_high_reg < 4'(PIN_START_CYC)) |=> !o_run)
    else $error("started too early after pin");
endmodule
